/* lldc_ctrl.sv */
// Function
// - Local write word is two memory beats; longer bursts take several cycles.
// - Two-beat burst: write data requested in one local cycle.
// - Init-done rises only after the memory init sequence has finished.
// - Read burst returns on the double-width read bus; longer bursts over several cycles.
// - Two-beat burst: whole read burst returned in one local cycle.
// - One read-valid flag per chip, high exactly with valid read data.
// - Strobe mode captures on read strobes; otherwise strobes are ignored.
// - Common I/O uses one two-way data bus for reads and writes.
// - Separate I/O writes on its output bus, reads on its input bus.
// - Drive three-bit bank address and row/column address of local width.
// - Drive differential memory clock pairs.
// - Drive active-low select, refresh, write enable; take per-chip read valid.
// - Refresh request refreshes the bank on the local bank address.
// - Local mask is twice memory mask; all high masks all data.
// - Second command bus, when enabled, copies the first; else held idle.
`timescale 1ns/1ps
module lldc_ctrl #(
	parameter int INIT_CYCLES = lldc_pkg::INIT_CYCLES
) (
	input  wire logic                                clock_in,
	input  wire logic                                rst_in,
	input  wire logic [1:0]                          burst_len_in,
	input  wire logic                                common_io_in,
	input  wire logic                                strobe_mode_in,
	input  wire logic                                dual_cmd_bus_in,
	input  wire logic [lldc_pkg::AW-1:0]             local_addr_in,
	input  wire logic [lldc_pkg::BA_W-1:0]           local_bank_addr_in,
	input  wire logic [2*lldc_pkg::DEV_N-1:0]        user_byte_mask_in,
	input  wire logic                                local_read_req_in,
	input  wire logic                                local_write_req_in,
	input  wire logic                                local_refresh_req_in,
	input  wire logic [2*lldc_pkg::DW-1:0]           local_wdata_in,
	output logic                                     local_ready_out,
	output logic                                     local_init_done_out,
	output logic                                     local_wdata_req_out,
	output logic [2*lldc_pkg::DW-1:0]                local_rdata_out,
	output logic [lldc_pkg::DEV_N-1:0]               local_rdata_valid_out,
	input  wire logic [lldc_pkg::DW-1:0]             mem_dq_in,
	output logic [lldc_pkg::DW-1:0]                  mem_dq_out,
	output logic [lldc_pkg::DW-1:0]                  mem_dq_oe_out,
	output logic [lldc_pkg::DW-1:0]                  mem_d_out,
	input  wire logic [lldc_pkg::DW-1:0]             mem_q_in,
	input  wire logic [lldc_pkg::DEV_N-1:0]          mem_qvld_in,
	input  wire logic [lldc_pkg::STB_N-1:0]          mem_read_strobe_in,
	output logic [lldc_pkg::STB_N-1:0]               mem_read_strobe_out,
	output logic [lldc_pkg::STB_N-1:0]               mem_read_strobe_oe_out,
	output logic [lldc_pkg::DEV_N-1:0]               mem_write_mask_out,
	output logic [lldc_pkg::CLK_N-1:0]               mem_clk_out,
	output logic [lldc_pkg::CLK_N-1:0]               mem_clk_n_out,
	output logic [lldc_pkg::AW-1:0]                  mem_a_0_out,
	output logic [lldc_pkg::AW-1:0]                  mem_a_1_out,
	output logic [lldc_pkg::BA_W-1:0]                mem_ba_0_out,
	output logic [lldc_pkg::BA_W-1:0]                mem_ba_1_out,
	output logic                                     mem_cs_n_0_out,
	output logic                                     mem_cs_n_1_out,
	output logic                                     mem_ref_n_0_out,
	output logic                                     mem_ref_n_1_out,
	output logic                                     mem_we_n_0_out,
	output logic                                     mem_we_n_1_out
);
	localparam int ICW = $clog2(INIT_CYCLES + 1);
	localparam int DW  = lldc_pkg::DW;
	localparam int N   = lldc_pkg::DEV_N;

	lldc_pkg::lldc_state_t state, next_state;
	logic [ICW-1:0]               init_cnt;
	logic [lldc_pkg::BA_W-1:0]    init_bank;
	logic [lldc_pkg::AW-1:0]      hold_addr;
	logic [lldc_pkg::BA_W-1:0]    hold_bank;
	logic [2:0]                   words, last_word, req_left, rd_left, beat_idx;
	logic [1:0]                   cap_idx;
	logic [6:0]                   rd_tmo;
	logic                         wd_take, go_ref, go_rd, go_wr, wr_cap_done, rd_done;
	logic [2*DW-1:0]              wbuf [lldc_pkg::MAX_WORDS];
	logic [2*N-1:0]               wmsk [lldc_pkg::MAX_WORDS];
	logic [2*DW-1:0]              cur_word;
	logic [2*N-1:0]               cur_msk;
	logic                         next_cs_n, next_we_n, next_ref_n;
	logic [lldc_pkg::AW-1:0]      next_a;
	logic [lldc_pkg::BA_W-1:0]    next_ba;

	lldc_beat_if bi ();

	////////////////////////////////////////////////////////////////////////////
	// Request decode: taken only in idle, so nothing is accepted before init
	assign words       = lldc_pkg::lldc_words(burst_len_in);
	assign last_word   = words - 3'h1;
	assign go_ref      = (state == lldc_pkg::ST_IDLE) && local_refresh_req_in;
	assign go_rd       = (state == lldc_pkg::ST_IDLE) && local_read_req_in && !go_ref;
	assign go_wr       = (state == lldc_pkg::ST_IDLE) && local_write_req_in
		&& !go_ref && !local_read_req_in;
	assign wr_cap_done = wd_take && ({1'b0, cap_idx} == last_word);
	assign rd_done     = (|bi.rd_valid && rd_left == 3'h1) || rd_tmo == lldc_pkg::RD_TMO_CYCLES;

	always_comb begin
		next_state = state;
		case (state)
			lldc_pkg::ST_INIT_WAIT:
				if (init_cnt == ICW'(INIT_CYCLES - 1)) next_state = lldc_pkg::ST_INIT_REF;
			lldc_pkg::ST_INIT_REF:
				if (init_bank == lldc_pkg::LAST_BANK) next_state = lldc_pkg::ST_IDLE;
			lldc_pkg::ST_IDLE: begin
				if (go_rd) next_state = lldc_pkg::ST_RD_WAIT;
				else if (go_wr) next_state = lldc_pkg::ST_WR_DATA;
			end
			lldc_pkg::ST_WR_DATA:
				if (wr_cap_done) next_state = lldc_pkg::ST_WR_BEAT;
			lldc_pkg::ST_WR_BEAT:
				if (beat_idx == {last_word[1:0], 1'b1}) next_state = lldc_pkg::ST_IDLE;
			lldc_pkg::ST_RD_WAIT:
				if (rd_done) next_state = lldc_pkg::ST_IDLE;
			default: next_state = lldc_pkg::ST_INIT_WAIT;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state           <= lldc_pkg::ST_INIT_WAIT;
			local_ready_out <= 1'b0;
		end else begin
			state           <= next_state;
			local_ready_out <= (next_state == lldc_pkg::ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-up wait, then a refresh to every bank
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			init_cnt            <= '0;
			init_bank           <= '0;
			local_init_done_out <= 1'b0;
		end else begin
			if (state == lldc_pkg::ST_INIT_WAIT) init_cnt <= init_cnt + ICW'(1);
			if (state == lldc_pkg::ST_INIT_REF) init_bank <= init_bank + 3'h1;
			if (state == lldc_pkg::ST_INIT_REF && init_bank == lldc_pkg::LAST_BANK)
				local_init_done_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write data: request, capture a cycle later, then serialise beats
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			local_wdata_req_out <= 1'b0;
			req_left            <= '0;
			wd_take             <= 1'b0;
			cap_idx             <= '0;
			beat_idx            <= '0;
			hold_addr           <= '0;
			hold_bank           <= '0;
		end else begin
			wd_take <= local_wdata_req_out;
			if (go_wr) begin
				local_wdata_req_out <= 1'b1;
				req_left            <= last_word;
				cap_idx             <= '0;
				hold_addr           <= local_addr_in;
				hold_bank           <= local_bank_addr_in;
			end else if (local_wdata_req_out) begin
				if (req_left == 3'h0) local_wdata_req_out <= 1'b0;
				else req_left <= req_left - 3'h1;
			end
			if (wd_take) cap_idx <= cap_idx + 2'h1;
			if (state == lldc_pkg::ST_WR_BEAT) beat_idx <= beat_idx + 3'h1;
			else beat_idx <= '0;
		end
	end

	// Storage is what lets the user stream words faster than the pins drain them
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < lldc_pkg::MAX_WORDS; i++) begin
				wbuf[i] <= '0;
				wmsk[i] <= '0;
			end
		end else if (wd_take) begin
			wbuf[cap_idx] <= local_wdata_in;
			wmsk[cap_idx] <= user_byte_mask_in;
		end
	end

	assign cur_word    = wbuf[beat_idx[2:1]];
	assign cur_msk     = wmsk[beat_idx[2:1]];
	assign bi.wr_valid = (state == lldc_pkg::ST_WR_BEAT);
	assign bi.wr_data  = beat_idx[0] ? cur_word[2*DW-1:DW] : cur_word[DW-1:0];
	assign bi.wr_mask  = beat_idx[0] ? cur_msk[2*N-1:N] : cur_msk[N-1:0];

	////////////////////////////////////////////////////////////////////////////
	// Read bookkeeping; the timeout keeps a silent memory from hanging us
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rd_left <= '0;
			rd_tmo  <= '0;
		end else if (go_rd) begin
			rd_left <= words;
			rd_tmo  <= '0;
		end else if (state == lldc_pkg::ST_RD_WAIT) begin
			rd_tmo <= rd_tmo + 7'h1;
			if (|bi.rd_valid) rd_left <= rd_left - 3'h1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			local_rdata_out       <= '0;
			local_rdata_valid_out <= '0;
		end else begin
			local_rdata_valid_out <= bi.rd_valid;
			if (|bi.rd_valid) local_rdata_out <= bi.rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command encode, registered onto both command buses
	always_comb begin
		next_cs_n  = 1'b1;
		next_we_n  = 1'b1;
		next_ref_n = 1'b1;
		next_a     = hold_addr;
		next_ba    = hold_bank;
		if (state == lldc_pkg::ST_INIT_REF) begin
			next_cs_n  = 1'b0;
			next_ref_n = 1'b0;
			next_ba    = init_bank;
		end else if (go_ref) begin
			next_cs_n  = 1'b0;
			next_ref_n = 1'b0;
			next_ba    = local_bank_addr_in;
		end else if (go_rd) begin
			next_cs_n = 1'b0;
			next_a    = local_addr_in;
			next_ba   = local_bank_addr_in;
		end else if (state == lldc_pkg::ST_WR_DATA && wr_cap_done) begin
			next_cs_n = 1'b0;
			next_we_n = 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mem_cs_n_0_out  <= 1'b1;
			mem_we_n_0_out  <= 1'b1;
			mem_ref_n_0_out <= 1'b1;
			mem_a_0_out     <= '0;
			mem_ba_0_out    <= '0;
		end else begin
			mem_cs_n_0_out  <= next_cs_n;
			mem_we_n_0_out  <= next_we_n;
			mem_ref_n_0_out <= next_ref_n;
			mem_a_0_out     <= next_a;
			mem_ba_0_out    <= next_ba;
		end
	end

	// When unused the copy holds select, refresh and write enable high and address and bank at zero, so an unconnected bus never commands
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mem_cs_n_1_out  <= 1'b1;
			mem_we_n_1_out  <= 1'b1;
			mem_ref_n_1_out <= 1'b1;
			mem_a_1_out     <= '0;
			mem_ba_1_out    <= '0;
		end else begin
			mem_cs_n_1_out  <= next_cs_n | ~dual_cmd_bus_in;
			mem_we_n_1_out  <= next_we_n | ~dual_cmd_bus_in;
			mem_ref_n_1_out <= next_ref_n | ~dual_cmd_bus_in;
			mem_a_1_out     <= dual_cmd_bus_in ? next_a : '0;
			mem_ba_1_out    <= dual_cmd_bus_in ? next_ba : '0;
		end
	end

	lldc_phy u_phy (
		.clock_in               (clock_in),
		.rst_in                 (rst_in),
		.common_io_in           (common_io_in),
		.strobe_mode_in         (strobe_mode_in),
		.bi                     (bi),
		.mem_clk_out            (mem_clk_out),
		.mem_clk_n_out          (mem_clk_n_out),
		.mem_dq_in              (mem_dq_in),
		.mem_dq_out             (mem_dq_out),
		.mem_dq_oe_out          (mem_dq_oe_out),
		.mem_d_out              (mem_d_out),
		.mem_q_in               (mem_q_in),
		.mem_qvld_in            (mem_qvld_in),
		.mem_read_strobe_in     (mem_read_strobe_in),
		.mem_read_strobe_out    (mem_read_strobe_out),
		.mem_read_strobe_oe_out (mem_read_strobe_oe_out),
		.mem_write_mask_out     (mem_write_mask_out)
	);

	////////////////////////////////////////////////////////////////////////////
	a_init_done_src: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(local_init_done_out) |-> $past(state) == lldc_pkg::ST_INIT_REF
		&& !mem_ref_n_0_out && mem_ba_0_out == lldc_pkg::LAST_BANK)
		else $error("init done before bank refresh sequence ended");
	a_wreq_single: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(local_wdata_req_out) && burst_len_in == lldc_pkg::BL_2
		|=> !local_wdata_req_out)
		else $error("two-beat write request not single cycle");
	a_wreq_bl8: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(local_wdata_req_out) && burst_len_in == lldc_pkg::BL_8
		|-> local_wdata_req_out[*4] ##1 !local_wdata_req_out)
		else $error("eight-beat write request length wrong");
	a_ref_bank: assert property (@(posedge clock_in) disable iff (rst_in)
		go_ref |=> !mem_cs_n_0_out && !mem_ref_n_0_out && mem_we_n_0_out
		&& mem_ba_0_out == $past(local_bank_addr_in))
		else $error("refresh not sent to requested bank");
	a_rd_cmd_addr: assert property (@(posedge clock_in) disable iff (rst_in)
		go_rd |=> !mem_cs_n_0_out && mem_we_n_0_out && mem_ref_n_0_out
		&& mem_a_0_out == $past(local_addr_in))
		else $error("read command or address wrong");
	a_copy_bus: assert property (@(posedge clock_in) disable iff (rst_in)
		$past(dual_cmd_bus_in) |-> mem_cs_n_1_out == mem_cs_n_0_out
		&& mem_a_1_out == mem_a_0_out && mem_we_n_1_out == mem_we_n_0_out)
		else $error("second command bus differs");
	a_rd_single: assert property (@(posedge clock_in) disable iff (rst_in)
		state == lldc_pkg::ST_RD_WAIT && burst_len_in == lldc_pkg::BL_2 && |bi.rd_valid
		|=> state == lldc_pkg::ST_IDLE ##1 local_rdata_valid_out == '0)
		else $error("two-beat read took more than one word");
	a_mask_all: assert property (@(posedge clock_in) disable iff (rst_in)
		wd_take && &user_byte_mask_in && burst_len_in == lldc_pkg::BL_2
		|=> ##1 &mem_write_mask_out ##1 &mem_write_mask_out)
		else $error("full mask did not mask both beats");

endmodule : lldc_ctrl

/* lldc_pkg.sv */
package lldc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int DEV_N     = 2;
	localparam int DEV_W     = 9;
	localparam int DW        = DEV_N * DEV_W;
	localparam int AW        = 20;
	localparam int BA_W      = 3;
	localparam int CLK_N     = 1;
	localparam int STB_N     = DEV_N;
	localparam int MAX_WORDS = 4;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_WAIT_NS  = 200000;
	localparam int INIT_CYCLES   = (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_TMO_NS     = 640;
	localparam logic [6:0] RD_TMO_CYCLES = 7'(RD_TMO_NS / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////
	// Burst length codes and bank range
	localparam logic [1:0] BL_2 = 2'h0;
	localparam logic [1:0] BL_4 = 2'h1;
	localparam logic [1:0] BL_8 = 2'h2;
	localparam logic [BA_W-1:0] LAST_BANK = 3'h7;

	typedef enum logic [2:0] {
		ST_INIT_WAIT = 3'h0,
		ST_INIT_REF  = 3'h1,
		ST_IDLE      = 3'h3,
		ST_WR_DATA   = 3'h2,
		ST_WR_BEAT   = 3'h6,
		ST_RD_WAIT   = 3'h7
	} lldc_state_t;

	// Local words per burst: each local word carries two memory beats
	function automatic logic [2:0] lldc_words(input logic [1:0] bl);
		case (bl)
			BL_2:    lldc_words = 3'h1;
			BL_4:    lldc_words = 3'h2;
			default: lldc_words = 3'h4;
		endcase
	endfunction : lldc_words

endpackage : lldc_pkg

/* lldc_beat_if.sv */
`timescale 1ns/1ps
interface lldc_beat_if;
	logic                              wr_valid;
	logic [lldc_pkg::DW-1:0]           wr_data;
	logic [lldc_pkg::DEV_N-1:0]        wr_mask;
	logic [lldc_pkg::DEV_N-1:0]        rd_valid;
	logic [2*lldc_pkg::DW-1:0]         rd_data;

	modport ctl (output wr_valid, output wr_data, output wr_mask,
		input rd_valid, input rd_data);
	modport phy (input wr_valid, input wr_data, input wr_mask,
		output rd_valid, output rd_data);
endinterface : lldc_beat_if

/* lldc_phy.sv */
`timescale 1ns/1ps
module lldc_phy (
	input  wire logic                             clock_in,
	input  wire logic                             rst_in,
	input  wire logic                             common_io_in,
	input  wire logic                             strobe_mode_in,
	lldc_beat_if.phy                              bi,
	output logic [lldc_pkg::CLK_N-1:0]            mem_clk_out,
	output logic [lldc_pkg::CLK_N-1:0]            mem_clk_n_out,
	input  wire logic [lldc_pkg::DW-1:0]          mem_dq_in,
	output logic [lldc_pkg::DW-1:0]               mem_dq_out,
	output logic [lldc_pkg::DW-1:0]               mem_dq_oe_out,
	output logic [lldc_pkg::DW-1:0]               mem_d_out,
	input  wire logic [lldc_pkg::DW-1:0]          mem_q_in,
	input  wire logic [lldc_pkg::DEV_N-1:0]       mem_qvld_in,
	input  wire logic [lldc_pkg::STB_N-1:0]       mem_read_strobe_in,
	output logic [lldc_pkg::STB_N-1:0]            mem_read_strobe_out,
	output logic [lldc_pkg::STB_N-1:0]            mem_read_strobe_oe_out,
	output logic [lldc_pkg::DEV_N-1:0]            mem_write_mask_out
);
	localparam int N = lldc_pkg::DEV_N;
	localparam int W = lldc_pkg::DEV_W;

	logic [W-1:0] cap_lo [N];
	logic [W-1:0] cap_hi [N];
	logic         cap_vld [N];

	////////////////////////////////////////////////////////////////////////////
	// Memory clock: divided from the system clock, one beat per system cycle
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mem_clk_out   <= '0;
			mem_clk_n_out <= '1;
		end else begin
			mem_clk_out   <= ~mem_clk_out;
			mem_clk_n_out <= ~mem_clk_n_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write drive; strobe lines are inputs only, never driven
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mem_dq_out             <= '0;
			mem_dq_oe_out          <= '0;
			mem_d_out              <= '0;
			mem_write_mask_out     <= '0;
			mem_read_strobe_out    <= '0;
			mem_read_strobe_oe_out <= '0;
		end else begin
			mem_dq_oe_out <= {lldc_pkg::DW{bi.wr_valid & common_io_in}};
			if (bi.wr_valid) begin
				if (common_io_in) begin
					mem_dq_out <= bi.wr_data;
				end else begin
					mem_d_out <= bi.wr_data;
				end
				mem_write_mask_out <= bi.wr_mask;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read capture, one lane per memory chip
	genvar d;
	generate
		for (d = 0; d < N; d++) begin : g_lane
			logic [W-1:0] q_s1, q_s2, lo;
			logic         v_s1, v_s2, k_s1, k_s2, k_s3, have_lo, beat;

			// Pins are asynchronous to us: two flops before any use
			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					q_s1 <= '0;
					q_s2 <= '0;
					v_s1 <= '0;
					v_s2 <= '0;
					k_s1 <= '0;
					k_s2 <= '0;
					k_s3 <= '0;
				end else begin
					q_s1 <= common_io_in ? mem_dq_in[d*W +: W] : mem_q_in[d*W +: W];
					q_s2 <= q_s1;
					v_s1 <= mem_qvld_in[d];
					v_s2 <= v_s1;
					k_s1 <= mem_read_strobe_in[d];
					k_s2 <= k_s1;
					k_s3 <= k_s2;
				end
			end

			// Strobe mode takes a beat on each strobe edge; otherwise valid alone
			assign beat = strobe_mode_in ? (v_s2 & (k_s2 ^ k_s3)) : v_s2;

			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					lo         <= '0;
					have_lo    <= 1'b0;
					cap_lo[d]  <= '0;
					cap_hi[d]  <= '0;
					cap_vld[d] <= 1'b0;
				end else begin
					cap_vld[d] <= 1'b0;
					if (beat && !have_lo) begin
						lo      <= q_s2;
						have_lo <= 1'b1;
					end else if (beat) begin
						cap_lo[d]  <= lo;
						cap_hi[d]  <= q_s2;
						cap_vld[d] <= 1'b1;
						have_lo    <= 1'b0;
					end else if (!v_s2) begin
						have_lo <= 1'b0;
					end
				end
			end

			a_lane_pulse: assert property (@(posedge clock_in) disable iff (rst_in)
				cap_vld[d] |=> !cap_vld[d])
				else $error("read valid held two cycles");
		end
	endgenerate

	always_comb begin
		for (int i = 0; i < N; i++) begin
			bi.rd_data[i*W +: W]                  = cap_lo[i];
			bi.rd_data[lldc_pkg::DW + i*W +: W]   = cap_hi[i];
			bi.rd_valid[i]                        = cap_vld[i];
		end
	end

	a_sio_no_oe: assert property (@(posedge clock_in) disable iff (rst_in)
		!common_io_in && $past(common_io_in) == 1'b0 |-> mem_dq_oe_out == '0)
		else $error("common bus driven in separate mode");
	a_cio_oe: assert property (@(posedge clock_in) disable iff (rst_in)
		bi.wr_valid && common_io_in |=> mem_dq_oe_out == '1 && mem_dq_out == $past(bi.wr_data))
		else $error("common bus not driven with write beat");
	a_clk_pair: assert property (@(posedge clock_in) disable iff (rst_in)
		!$past(rst_in) |-> mem_clk_n_out == ~mem_clk_out && mem_clk_out != $past(mem_clk_out))
		else $error("memory clock pair not toggling in opposition");

endmodule : lldc_phy

/* lldc_mem_model.sv */
`timescale 1ns/1ps
module lldc_mem_model #(
	parameter int LAT = 3
) (
	input  wire logic        clk_in,
	input  wire logic        cio_in,
	input  wire logic [1:0]  bl_in,
	input  wire logic        cs_n_in,
	input  wire logic        we_n_in,
	input  wire logic        ref_n_in,
	input  wire logic [19:0] a_in,
	input  wire logic [17:0] dq_in,
	input  wire logic [17:0] d_in,
	output logic [17:0]      dq_out   = 18'h0,
	output logic [17:0]      q_out    = 18'h0,
	output logic [1:0]       qvld_out = 2'h0,
	output logic [1:0]       stb_out  = 2'h0
);
	logic [17:0] mem [int];
	logic [19:0] wa;
	logic [19:0] ra;
	logic [17:0] v  = 18'h0;
	int          wn = 0;
	int          rn = 0;
	int          n;
	always @(posedge clk_in) begin
		n = (bl_in == 2'h0) ? 2 : (bl_in == 2'h1) ? 4 : 8;
		if (wn > 0) begin
			mem[wa * 8 + n - wn] = cio_in ? dq_in : d_in;
			wn--;
		end
		if (rn > 0)
			rn--;
		if (!cs_n_in && !we_n_in) begin
			wn = n;
			wa = a_in;
		end
		if (!cs_n_in && we_n_in && ref_n_in) begin
			rn = LAT + n;
			ra = a_in;
		end
		// Released bus shows inverted last value so stale data cannot pass
		v = (rn > 0 && rn <= n) ? mem[ra * 8 + n - rn] : ~v;
		qvld_out <= (rn > 0 && rn <= n) ? 2'h3 : 2'h0;
		stb_out  <= (rn > 0 && rn <= n) ? ~stb_out : stb_out;
		dq_out   <= cio_in ? v : ~v;
		q_out    <= cio_in ? ~v : v;
	end
endmodule : lldc_mem_model

/* test_lldc_ctrl.sv */
`timescale 1ns/1ps
module test_lldc_ctrl;
	logic clock_in, rst_in, common_io, smode, dual, rreq, wreq, fref, rdy, done, wdreq;
	logic cs0, cs1, we0, we1, ref0, ref1;
	logic [1:0] bl, rvld, qvld, stb, wmask;
	logic [2:0] bank, ba0, ba1;
	logic [3:0] bmask;
	logic [19:0] addr, a0;
	logic [35:0] wdata, rdata;
	logic [17:0] dqo, dqoe, dout, mdq, mq, dqw;
	int fails = 0, n_compared = 0, n_ref = 0, cyc = 0, w, t;
	assign dqw = (dqoe & dqo) | (~dqoe & mdq);
	lldc_ctrl #(.INIT_CYCLES(20)) DUT (.clock_in(clock_in), .rst_in(rst_in),
		.burst_len_in(bl), .common_io_in(common_io), .strobe_mode_in(smode),
		.dual_cmd_bus_in(dual), .local_addr_in(addr), .local_bank_addr_in(bank),
		.user_byte_mask_in(bmask), .local_read_req_in(rreq), .local_write_req_in(wreq),
		.local_refresh_req_in(fref), .local_wdata_in(wdata), .local_ready_out(rdy),
		.local_init_done_out(done), .local_wdata_req_out(wdreq), .local_rdata_out(rdata),
		.local_rdata_valid_out(rvld), .mem_dq_in(dqw), .mem_dq_out(dqo),
		.mem_dq_oe_out(dqoe), .mem_d_out(dout), .mem_q_in(mq), .mem_qvld_in(qvld),
		.mem_read_strobe_in(stb), .mem_read_strobe_out(), .mem_read_strobe_oe_out(),
		.mem_write_mask_out(wmask), .mem_clk_out(), .mem_clk_n_out(), .mem_a_0_out(a0),
		.mem_a_1_out(), .mem_ba_0_out(ba0), .mem_ba_1_out(ba1), .mem_cs_n_0_out(cs0),
		.mem_cs_n_1_out(cs1), .mem_ref_n_0_out(ref0), .mem_ref_n_1_out(ref1),
		.mem_we_n_0_out(we0), .mem_we_n_1_out(we1));
	lldc_mem_model mem (.clk_in(clock_in), .cio_in(common_io), .bl_in(bl), .cs_n_in(cs0),
		.we_n_in(we0), .ref_n_in(ref0), .a_in(a0), .dq_in(dqw), .d_in(dout),
		.dq_out(mdq), .q_out(mq), .qvld_out(qvld), .stb_out(stb));
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [35:0] wd(input int b, input int k);
		wd = {18'(b + 2 * k + 1), 18'(b + 2 * k)};
	endfunction : wd
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic req(input logic [19:0] ad, input int kind);
		while (!rdy) @(negedge clock_in);
		addr = ad;
		rreq = (kind == 0);
		wreq = (kind == 1);
		fref = (kind == 2);
		@(negedge clock_in);
		{rreq, wreq, fref} = 3'h0;
	endtask : req
	task automatic wr(input logic [19:0] ad, input logic [3:0] m, input int b);
		int k;
		logic hit, pw;
		k = 0;
		hit = 0;
		pw = 0;
		bmask = m;
		req(ad, 1);
		for (t = 0; t < 60 && !(k == w && rdy); t++) begin
			hit |= (wmask === 2'h3);
			// Word is taken the cycle after each request cycle
			if (pw) begin
				wdata = wd(b, k);
				k++;
			end
			pw = wdreq;
			@(negedge clock_in);
		end
		chk(36'(k), 36'(w));
		chk(36'(hit), 36'(m == 4'hf));
	endtask : wr
	task automatic rd(input logic [19:0] ad, input int b);
		int k;
		k = 0;
		req(ad, 0);
		chk(36'({cs0, we0, ref0, a0}), 36'({3'h3, ad}));
		for (t = 0; t < 100 && k < w; t++) begin
			@(negedge clock_in);
			if (rvld !== 2'h0) begin
				chk(36'(rvld), 36'h3);
				chk(rdata, wd(b, k));
				k++;
			end
		end
		chk(36'(k), 36'(w));
	endtask : rd
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clock_in = 0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (!rst_in && !ref0)
			n_ref++;
		if (cyc == 5000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		{common_io, smode, dual, bl, bank, bmask, addr, wdata} = '0;
		{rreq, wreq, fref} = 3'h0;
		rst_in = 1;
		repeat (20) @(negedge clock_in);
		rst_in = 0;
		chk(36'(done), 36'h0);
		for (t = 0; t < 200 && !done; t++) @(negedge clock_in);
		// Last bank refresh stands on the pins in the cycle done rises
		@(negedge clock_in);
		chk(36'(n_ref), 36'h8);
		// Requests start only once init is reported done
		for (int i = 0; i < 6; i++) begin
			common_io = (i < 3);
			bl = 2'(i % 3);
			smode = (i % 3 == 2);
			w = 1 << (i % 3);
			wr(20'h100 + 20'(i), 4'h0, 16 * i);
			rd(20'h100 + 20'(i), 16 * i);
		end
		bl = 2'h0;
		w = 1;
		wr(20'h200, 4'hf, 0);
		for (int i = 0; i < 2; i++) begin
			dual = i[0];
			bank = 3'h5 - 3'(i);
			req(20'h0, 2);
			chk(36'({ref0, ref1, ba0, ba1}), 36'({1'b0, !dual, bank, dual ? bank : 3'h0}));
			@(negedge clock_in);
		end
		close_out();
	end
endmodule : test_lldc_ctrl
